// >>> design/csbp_defines.vh
// Constants shared by the configuration port top level and its test files
`ifndef CSBP_DEFINES_VH
`define CSBP_DEFINES_VH

// Timing: 80 ns master half period, 640 ns clear, at a 20 ns clock
// The two cycle counts are sized, so they meet the 8-bit counters without truncation; the chain delay is unsized
`define CSBP_MCLK_HALF_CYC 8'h04
`define CSBP_CLEAR_CYC 8'h20
`define CSBP_FWD_DELAY 40

// Mode pin codes
`define CSBP_MODE_MSER 3'h0
`define CSBP_MODE_SSER 3'h7
`define CSBP_MODE_PAR 3'h6

// Stream framing
`define CSBP_SYNC_WORD 32'hA5C35A3C
`define CSBP_CRC_INIT 16'hFFFF
`define CSBP_CRC_POLY 16'h1021

// Data path
`define CSBP_FIFO_DEPTH 16
`define CSBP_FIFO_AW 4

`endif

// >>> design/csbp_sync.v
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module csbp_sync #(
  parameter W = 1
) (
  input wire clk_in,
  input wire rstn_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts only once stages two and three agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// >>> design/csbp_fifo.v
// Configuration data FIFO with valid/ready on both sides
`timescale 1ns/1ps
module csbp_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire rstn_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready_out = (cnt_r != D);
  assign out_valid_out = (cnt_r != 0);
  assign out_data_out = mem[rd_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_r] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// >>> design/csbp_top.v
// Configuration port: serial and byte-wide loading, chaining, start-up
`timescale 1ns/1ps
`include "csbp_defines.vh"
module csbp_top (
  // Clock and reconfiguration reset
  input wire CLK_IN,
  input wire RSTN_IN,
  // Configuration clock pin
  input wire CFG_CLK_IN,
  output wire CFG_CLK_OUT,
  output wire CFG_CLK_OE_OUT,
  // Serial data and shared busy/chain pin
  input wire SER_DIN_IN,
  output wire BUSY_CHAIN_OUT,
  output wire BUSY_CHAIN_OE_OUT,
  // Parallel byte port
  input wire PORT_SEL_N_IN,
  input wire PORT_WRITE_N_IN,
  input wire [7:0] PORT_BYTE_BUS_IN,
  output wire [7:0] PORT_BYTE_BUS_OUT,
  output wire PORT_BYTE_BUS_OE_OUT,
  // Status and mode pins
  input wire INIT_N_IN,
  output wire INIT_N_OUT,
  output wire INIT_N_OE_OUT,
  input wire DONE_IN,
  output wire DONE_OUT,
  output wire DONE_OE_OUT,
  input wire [2:0] MODE_SELECT_PINS_IN,
  input wire ACTIVE_STATUS_DRIVE_IN,
  // Core side
  output wire GLOBAL_OUTPUT_HOLD_OUT,
  output wire GLOBAL_STORE_ENABLE_OUT,
  output wire GLOBAL_FLOP_RESET_OUT,
  output wire [7:0] CFG_DATA_OUT,
  output wire CFG_DATA_VALID_OUT,
  input wire CFG_DATA_READY_IN,
  input wire [7:0] RB_DATA_IN,
  output wire RB_TAKE_OUT,
  output wire CFG_ERROR_OUT,
  output wire [2:0] MODE_OUT
);
  localparam S_CLEAR = 4'h0;
  localparam S_WINIT = 4'h1;
  localparam S_SYNC = 4'h2;
  localparam S_LENH = 4'h3;
  localparam S_LENL = 4'h4;
  localparam S_DATA = 4'h5;
  localparam S_CRCH = 4'h6;
  localparam S_CRCL = 4'h7;
  localparam S_START = 4'h8;
  localparam S_ACTIVE = 4'h9;
  localparam S_ERR = 4'hA;
  localparam [7:0] MHALF = `CSBP_MCLK_HALF_CYC;
  localparam [7:0] CLRCYC = `CSBP_CLEAR_CYC;
  localparam DLY = `CSBP_FWD_DELAY;

  function [7:0] rev8;
    input [7:0] b;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = b[7-k];
      end
    end
  endfunction

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] b;
    integer k;
    reg [15:0] t;
    begin
      t = c ^ {b, 8'h00};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[15] ? ({t[14:0], 1'b0} ^ `CSBP_CRC_POLY) : {t[14:0], 1'b0};
      end
      crc_step = t;
    end
  endfunction

  wire [16:0] sy;
  wire ck_s;
  wire din_s;
  wire sel_s;
  wire wrn_s;
  wire [7:0] bus_s;
  wire init_s;
  wire done_s;
  wire [2:0] mode_s;

  csbp_sync #(.W(17)) u_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .d_in({CFG_CLK_IN, SER_DIN_IN, ~PORT_SEL_N_IN, PORT_WRITE_N_IN,
           PORT_BYTE_BUS_IN, INIT_N_IN, DONE_IN, MODE_SELECT_PINS_IN}),
    .q_out(sy)
  );
  assign {ck_s, din_s, sel_s, wrn_s, bus_s, init_s, done_s, mode_s} = sy;

  reg [3:0] st_r;
  reg [3:0] st_nxt;
  reg [2:0] mode_r;
  reg ck_prev_r;
  reg init_prev_r;
  reg mclk_r;
  reg [7:0] mcnt_r;
  reg [7:0] clr_r;
  reg [7:0] sh_r;
  reg [2:0] bcnt_r;
  reg [23:0] hunt_r;
  reg [15:0] len_r;
  reg [15:0] crc_r;
  reg [7:0] crcx_r;
  reg fwd_r;
  reg [DLY-1:0] dly_r;
  reg [1:0] ph_r;
  reg done_rel_r;
  reg hold_r;
  reg gwe_r;
  reg gsr_r;
  reg [7:0] rb_r;
  reg rb_take_r;

  wire is_master = (mode_r == `CSBP_MODE_MSER);
  wire is_par = (mode_r == `CSBP_MODE_PAR);
  wire loading = (st_r >= S_SYNC) && (st_r <= S_CRCL);
  wire master_run = is_master && (st_r != S_CLEAR) && (st_r != S_WINIT);
  wire m_rise = master_run && !mclk_r && (mcnt_r == MHALF - 8'h01);
  wire ext_rise = ck_s && !ck_prev_r;
  wire edge_ev = is_master ? m_rise : ext_rise;
  wire fifo_rdy;
  wire busy = !fifo_rdy;

  // Byte assembly: serial bits, or a captured parallel byte
  wire ser_bit = edge_ev && !is_par && loading && !fwd_r;
  wire [7:0] ser_byte = {sh_r[6:0], din_s};
  wire par_wr = edge_ev && is_par && sel_s && !wrn_s && !busy;
  wire byte_ev = (ser_bit && (bcnt_r == 3'h7)) || (par_wr && loading);
  wire [7:0] byte_v = is_par ? rev8(bus_s) : ser_byte;
  wire par_abort = edge_ev && is_par && sel_s && wrn_s && loading;
  wire push = byte_ev && (st_r == S_DATA);

  csbp_fifo #(.W(8), .D(`CSBP_FIFO_DEPTH), .AW(`CSBP_FIFO_AW)) u_fifo (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .in_valid_in(push),
    .in_ready_out(fifo_rdy),
    .in_data_in(byte_v),
    .out_valid_out(CFG_DATA_VALID_OUT),
    .out_ready_in(CFG_DATA_READY_IN),
    .out_data_out(CFG_DATA_OUT)
  );

  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_CLEAR: if (clr_r == CLRCYC) st_nxt = S_WINIT;
      S_WINIT: if (init_s && !init_prev_r) st_nxt = S_SYNC;
      S_SYNC: if (byte_ev && {hunt_r, byte_v} == `CSBP_SYNC_WORD)
        st_nxt = S_LENH;
      S_LENH: if (byte_ev) st_nxt = S_LENL;
      S_LENL: if (byte_ev)
        st_nxt = ({len_r[15:8], byte_v} == 16'h0000) ? S_CRCH : S_DATA;
      S_DATA: begin
        if (byte_ev && !fifo_rdy) begin
          // Serial data cannot be stalled, so overrun is fatal
          st_nxt = S_ERR;
        end else if (byte_ev && len_r == 16'h0001) begin
          st_nxt = S_CRCH;
        end
      end
      S_CRCH: if (byte_ev) st_nxt = S_CRCL;
      S_CRCL: if (byte_ev)
        st_nxt = ({crcx_r, byte_v} == crc_r) ? S_START : S_ERR;
      S_START: if (edge_ev && ph_r == 2'h3) st_nxt = S_ACTIVE;
      S_ACTIVE: st_nxt = S_ACTIVE;
      S_ERR: st_nxt = S_ERR;
      default: st_nxt = S_ERR;
    endcase
    if (par_abort) begin
      st_nxt = S_ERR;
    end
  end

  always @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_r <= S_CLEAR;
      mode_r <= `CSBP_MODE_SSER;
      ck_prev_r <= 1'b0;
      init_prev_r <= 1'b0;
      mclk_r <= 1'b0;
      mcnt_r <= 8'h00;
      clr_r <= 8'h00;
      sh_r <= 8'h00;
      bcnt_r <= 3'h0;
      hunt_r <= 24'h000000;
      len_r <= 16'h0000;
      crc_r <= `CSBP_CRC_INIT;
      crcx_r <= 8'h00;
      fwd_r <= 1'b0;
      dly_r <= {DLY{1'b1}};
      ph_r <= 2'h0;
      done_rel_r <= 1'b0;
      hold_r <= 1'b1;
      gwe_r <= 1'b0;
      gsr_r <= 1'b1;
      rb_r <= 8'h00;
      rb_take_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ck_prev_r <= ck_s;
      init_prev_r <= init_s;
      rb_take_r <= 1'b0;
      if (st_r == S_CLEAR && clr_r != CLRCYC) begin
        clr_r <= clr_r + 8'h01;
      end
      if (st_r == S_WINIT && init_s && !init_prev_r) begin
        mode_r <= mode_s;
      end
      // Master clock stays still until init completes
      if (master_run) begin
        if (mcnt_r == MHALF - 8'h01) begin
          mcnt_r <= 8'h00;
          mclk_r <= !mclk_r;
        end else begin
          mcnt_r <= mcnt_r + 8'h01;
        end
      end
      if (ser_bit) begin
        sh_r <= ser_byte;
        bcnt_r <= bcnt_r + 3'h1;
      end
      if (byte_ev) begin
        hunt_r <= {hunt_r[15:0], byte_v};
        case (st_r)
          S_LENH: len_r[15:8] <= byte_v;
          S_LENL: begin
            len_r[7:0] <= byte_v;
            crc_r <= `CSBP_CRC_INIT;
          end
          S_DATA: begin
            crc_r <= crc_step(crc_r, byte_v);
            len_r <= len_r - 16'h0001;
          end
          S_CRCH: crcx_r <= byte_v;
          S_CRCL: fwd_r <= !is_par && ({crcx_r, byte_v} == crc_r);
          default: hunt_r <= {hunt_r[15:0], byte_v};
        endcase
      end
      // Chain path idles high until own stream checks out
      if (edge_ev && !is_par) begin
        dly_r <= {dly_r[DLY-2:0], fwd_r ? din_s : 1'b1};
      end
      if (st_r == S_START && edge_ev) begin
        case (ph_r)
          2'h0: begin
            done_rel_r <= 1'b1;
            if (done_rel_r && done_s) ph_r <= 2'h1;
          end
          2'h1: begin
            hold_r <= 1'b0;
            ph_r <= 2'h2;
          end
          2'h2: begin
            gwe_r <= 1'b1;
            ph_r <= 2'h3;
          end
          default: gsr_r <= 1'b0;
        endcase
      end
      if (st_r == S_ACTIVE && is_par && edge_ev && sel_s && wrn_s) begin
        rb_r <= rev8(RB_DATA_IN);
        rb_take_r <= 1'b1;
      end
    end
  end

  assign CFG_CLK_OUT = mclk_r;
  assign CFG_CLK_OE_OUT = is_master && master_run;
  // Pin shared: busy in byte mode, chain data in serial modes
  assign BUSY_CHAIN_OUT = is_par ? busy : dly_r[DLY-1];
  assign BUSY_CHAIN_OE_OUT = is_par ? sel_s : 1'b1;
  assign PORT_BYTE_BUS_OUT = rb_r;
  assign PORT_BYTE_BUS_OE_OUT =
    is_par && sel_s && wrn_s && (st_r == S_ACTIVE);
  assign INIT_N_OUT = 1'b0;
  assign INIT_N_OE_OUT = (st_r == S_CLEAR) || (st_r == S_ERR);
  assign DONE_OUT = done_rel_r;
  assign DONE_OE_OUT = !done_rel_r || ACTIVE_STATUS_DRIVE_IN;
  assign GLOBAL_OUTPUT_HOLD_OUT = hold_r;
  assign GLOBAL_STORE_ENABLE_OUT = gwe_r;
  assign GLOBAL_FLOP_RESET_OUT = gsr_r;
  assign RB_TAKE_OUT = rb_take_r;
  assign CFG_ERROR_OUT = (st_r == S_ERR);
  assign MODE_OUT = mode_r;
endmodule

// >>> test/csbp_asserts.sv
// Port assertions for the configuration port
`timescale 1ns/1ps
`include "csbp_defines.vh"
module csbp_asserts (
  input wire CLK_IN,
  input wire RSTN_IN,
  input wire CFG_CLK_OE_OUT,
  input wire BUSY_CHAIN_OUT,
  input wire BUSY_CHAIN_OE_OUT,
  input wire PORT_SEL_N_IN,
  input wire [7:0] PORT_BYTE_BUS_OUT,
  input wire PORT_BYTE_BUS_OE_OUT,
  input wire [7:0] RB_DATA_IN,
  input wire RB_TAKE_OUT,
  input wire INIT_N_OE_OUT,
  input wire DONE_IN,
  input wire DONE_OUT,
  input wire GLOBAL_OUTPUT_HOLD_OUT,
  input wire GLOBAL_STORE_ENABLE_OUT,
  input wire GLOBAL_FLOP_RESET_OUT,
  input wire CFG_ERROR_OUT,
  input wire [2:0] MODE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  function automatic [7:0] rev8(input [7:0] b);
    integer i;
    for (i = 0; i < 8; i = i + 1) rev8[i] = b[7 - i];
  endfunction
  property p_rd_drive;
    PORT_BYTE_BUS_OE_OUT |-> MODE_OUT == `CSBP_MODE_PAR &&
      !GLOBAL_FLOP_RESET_OUT;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("byte bus driven outside readback");
  property p_rb_data;
    RB_TAKE_OUT |-> PORT_BYTE_BUS_OUT == rev8($past(RB_DATA_IN)) ##1
      !RB_TAKE_OUT;
  endproperty
  a_rb_data: assert property (p_rb_data)
    else $error("readback byte order or pulse wrong");
  property p_busy_hiz;
    PORT_SEL_N_IN [*6] ##0 MODE_OUT == `CSBP_MODE_PAR |-> !BUSY_CHAIN_OE_OUT;
  endproperty
  a_busy_hiz: assert property (p_busy_hiz)
    else $error("busy driven while deselected");
  property p_chain_idle;
    MODE_OUT != `CSBP_MODE_PAR && !DONE_OUT |-> BUSY_CHAIN_OUT;
  endproperty
  a_chain_idle: assert property (p_chain_idle)
    else $error("chain output left idle early");
  property p_done_first;
    $fell(GLOBAL_OUTPUT_HOLD_OUT) |-> DONE_OUT && DONE_IN;
  endproperty
  a_done_first: assert property (p_done_first)
    else $error("outputs released before completion");
  property p_store;
    $rose(GLOBAL_STORE_ENABLE_OUT) |-> !GLOBAL_OUTPUT_HOLD_OUT && DONE_OUT;
  endproperty
  a_store: assert property (p_store)
    else $error("store enabled out of order");
  property p_flop;
    $fell(GLOBAL_FLOP_RESET_OUT) |-> GLOBAL_STORE_ENABLE_OUT;
  endproperty
  a_flop: assert property (p_flop)
    else $error("flop reset released out of order");
  property p_err_init;
    CFG_ERROR_OUT |-> INIT_N_OE_OUT && GLOBAL_OUTPUT_HOLD_OUT;
  endproperty
  a_err_init: assert property (p_err_init)
    else $error("error without init low");
  property p_err_hold;
    CFG_ERROR_OUT |=> CFG_ERROR_OUT;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error cleared without reset");
  property p_master;
    CFG_CLK_OE_OUT |-> MODE_OUT == `CSBP_MODE_MSER && !INIT_N_OE_OUT;
  endproperty
  a_master: assert property (p_master)
    else $error("clock driven outside master mode");
  c_active: cover property ($fell(GLOBAL_FLOP_RESET_OUT));
  c_error: cover property ($rose(CFG_ERROR_OUT));
  c_rb: cover property (RB_TAKE_OUT);
endmodule
bind csbp_top csbp_asserts chk_u (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CFG_CLK_OE_OUT(CFG_CLK_OE_OUT),
  .BUSY_CHAIN_OUT(BUSY_CHAIN_OUT), .BUSY_CHAIN_OE_OUT(BUSY_CHAIN_OE_OUT),
  .PORT_SEL_N_IN(PORT_SEL_N_IN), .PORT_BYTE_BUS_OUT(PORT_BYTE_BUS_OUT),
  .PORT_BYTE_BUS_OE_OUT(PORT_BYTE_BUS_OE_OUT), .RB_DATA_IN(RB_DATA_IN),
  .RB_TAKE_OUT(RB_TAKE_OUT), .INIT_N_OE_OUT(INIT_N_OE_OUT),
  .DONE_IN(DONE_IN), .DONE_OUT(DONE_OUT),
  .GLOBAL_OUTPUT_HOLD_OUT(GLOBAL_OUTPUT_HOLD_OUT),
  .GLOBAL_STORE_ENABLE_OUT(GLOBAL_STORE_ENABLE_OUT),
  .GLOBAL_FLOP_RESET_OUT(GLOBAL_FLOP_RESET_OUT),
  .CFG_ERROR_OUT(CFG_ERROR_OUT), .MODE_OUT(MODE_OUT)
);

// >>> test/csbp_host_model.sv
// Far-side host model: config clock, serial data and byte port
`timescale 1ns/1ps
module csbp_host_model (
  input wire clk_in,
  input wire chain_in,
  output reg config_clock_out,
  output reg ser_out,
  output reg sel_n_out,
  output reg write_n_out,
  output reg [7:0] bus_out
);
  initial begin
    config_clock_out = 1'b0;
    ser_out = 1'b0;
    sel_n_out = 1'b1;
    write_n_out = 1'b0;
    bus_out = 8'h00;
  end
  // One 160 ns clock; pins stay put 5 cycles past the rise for the syncs
  task automatic cyc(input d, input s, input w, input [7:0] b, output q);
    begin
      @(posedge clk_in);
      ser_out <= d;
      sel_n_out <= s;
      write_n_out <= w;
      bus_out <= b;
      repeat (3) @(posedge clk_in);
      config_clock_out <= 1'b1;
      #1 q = chain_in;
      repeat (4) @(posedge clk_in);
      config_clock_out <= 1'b0;
    end
  endtask
  task automatic ser_byte(input [7:0] b);
    integer i;
    reg q;
    for (i = 7; i >= 0; i = i - 1)
      cyc(b[i], 1'b1, 1'b0, ~bus_out, q);
  endtask
  // Re-presents the byte while busy was seen high at the rise
  task automatic wr_byte(input [7:0] bb);
    reg q;
    begin
      q = 1'b1;
      while (q !== 1'b0)
        cyc(~ser_out, 1'b0, 1'b0, bb, q);
    end
  endtask
  // Clock stands low; released lines show changing values
  task automatic park;
    begin
      @(posedge clk_in);
      sel_n_out <= 1'b1;
      ser_out <= ~ser_out;
      bus_out <= ~bus_out;
    end
  endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the configuration port
`timescale 1ns/1ps
`include "csbp_defines.vh"
module testbench;
  reg clk, rstn = 1'b0, rdy = 1'b1, act = 1'b0, q;
  reg [2:0] mode = 3'h7;
  reg [7:0] rb = 8'h00;
  reg [7:0] expq[$];
  reg [47:0] smp = 48'h0;
  integer n_mismatch = 0, compares = 0, cyc_n = 0, i;
  wire config_clock, ser, sel_n, wr_n, clk_oe, config_clock_o, chain, chain_oe, bus_oe;
  wire init_o, init_oe, done_o, done_oe, ghold, gstore, gflop, cvalid;
  wire rbtake, err;
  wire [7:0] hbus, bus_o, cdata;
  wire [2:0] mode_o;
  wire init_w = init_oe ? init_o : 1'b1;
  wire done_w = done_oe ? done_o : 1'b1;
  wire config_clock_w = clk_oe ? config_clock_o : config_clock;
  wire [7:0] bus_w = bus_oe ? bus_o : hbus;
  localparam [7:0] CHAIN_PAT = 8'h5A;
  csbp_host_model host_u (.clk_in(clk), .chain_in(chain), .config_clock_out(config_clock),
    .ser_out(ser), .sel_n_out(sel_n), .write_n_out(wr_n), .bus_out(hbus));
  csbp_top dut_u (.CLK_IN(clk), .RSTN_IN(rstn), .CFG_CLK_IN(config_clock_w),
    .CFG_CLK_OUT(config_clock_o), .CFG_CLK_OE_OUT(clk_oe), .SER_DIN_IN(ser),
    .BUSY_CHAIN_OUT(chain), .BUSY_CHAIN_OE_OUT(chain_oe),
    .PORT_SEL_N_IN(sel_n), .PORT_WRITE_N_IN(wr_n), .PORT_BYTE_BUS_IN(bus_w),
    .PORT_BYTE_BUS_OUT(bus_o), .PORT_BYTE_BUS_OE_OUT(bus_oe),
    .INIT_N_IN(init_w), .INIT_N_OUT(init_o), .INIT_N_OE_OUT(init_oe),
    .DONE_IN(done_w), .DONE_OUT(done_o), .DONE_OE_OUT(done_oe),
    .MODE_SELECT_PINS_IN(mode), .ACTIVE_STATUS_DRIVE_IN(act),
    .GLOBAL_OUTPUT_HOLD_OUT(ghold), .GLOBAL_STORE_ENABLE_OUT(gstore),
    .GLOBAL_FLOP_RESET_OUT(gflop), .CFG_DATA_OUT(cdata),
    .CFG_DATA_VALID_OUT(cvalid), .CFG_DATA_READY_IN(rdy),
    .RB_DATA_IN(rb), .RB_TAKE_OUT(rbtake), .CFG_ERROR_OUT(err),
    .MODE_OUT(mode_o));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task print_verdict;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [47:0] got, input [47:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  function automatic [15:0] crc16(input [15:0] c, input [7:0] b);
    integer k;
    begin
      crc16 = c;
      for (k = 7; k >= 0; k = k - 1)
        crc16 = {crc16[14:0], 1'b0} ^
          ((crc16[15] ^ b[k]) ? `CSBP_CRC_POLY : 16'h0000);
    end
  endfunction
  // Bus bit 0 carries the byte's most significant bit
  function automatic [7:0] flip(input [7:0] b);
    integer k;
    for (k = 0; k < 8; k = k + 1) flip[k] = b[7 - k];
  endfunction
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end else if (cvalid === 1'b1 && rdy === 1'b1) begin
      chk(cdata, expq.pop_front());
    end
  end
  task automatic restart(input [2:0] m);
    integer n;
    begin
      @(posedge clk);
      rstn <= 1'b0;
      mode <= m;
      repeat (20) @(posedge clk);
      chk({init_oe, gflop, clk_oe}, 3'b110);
      rstn <= 1'b1;
      n = 0;
      while (init_w !== 1'b1 && n < 200) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(init_w, 1'b1);
      repeat (10) @(posedge clk);
      chk(mode_o, m);
      chk(clk_oe, m == `CSBP_MODE_MSER);
    end
  endtask
  task automatic put(input par, input [7:0] b);
    if (par) host_u.wr_byte(flip(b));
    else host_u.ser_byte(b);
  endtask
  task automatic idle(input integer n);
    repeat (n) host_u.cyc(1'b1, 1'b1, 1'b1, 8'h00, q);
  endtask
  task automatic stream(input par, input [7:0] n, input bad);
    integer k;
    reg [15:0] crc;
    reg [31:0] sw;
    reg [7:0] d;
    begin
      crc = `CSBP_CRC_INIT;
      sw = `CSBP_SYNC_WORD;
      for (k = 3; k >= 0; k = k - 1) put(par, sw[8 * k +: 8]);
      put(par, 8'h00);
      put(par, n);
      for (k = 0; k < n; k = k + 1) begin
        d = 8'h3C + 8'h1D * k[7:0];
        if (par && k == 16) begin
          host_u.cyc(1'b0, 1'b0, 1'b0, flip(d), q);
          chk(q, 1'b1);
          rdy <= 1'b1;
        end
        expq.push_back(d);
        crc = crc16(crc, d);
        put(par, d);
      end
      crc = crc ^ {15'h0000, bad};
      put(par, crc[15:8]);
      put(par, crc[7:0]);
    end
  endtask
  initial begin
    restart(`CSBP_MODE_MSER);
    // Master clock: 4 cycles high, 4 low, repeating
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge clk);
      smp = {smp[46:0], config_clock_o};
    end
    chk({smp[7:4] ^ smp[3:0], smp[15:8] ^ smp[7:0]}, 12'hF00);
    restart(`CSBP_MODE_SSER);
    stream(1'b0, 8'd3, 1'b0);
    for (i = 0; i < 48; i = i + 1) begin
      host_u.cyc(i < 8 ? CHAIN_PAT[7 - i] : 1'b1, 1'b1, 1'b0, 8'h00, q);
      smp = {smp[46:0], q};
    end
    chk(smp, {40'hFFFFFFFFFF, CHAIN_PAT});
    chk({done_o, ghold, gstore, gflop, err}, 5'b10100);
    restart(`CSBP_MODE_SSER);
    stream(1'b0, 8'd3, 1'b1);
    idle(4);
    chk({err, init_oe, ghold, done_o}, 4'b1110);
    restart(`CSBP_MODE_PAR);
    act <= 1'b1;
    rdy <= 1'b0;
    stream(1'b1, 8'd18, 1'b0);
    host_u.park;
    // Start-up needs five clock rises; a rise acts after its cycle
    idle(8);
    chk({done_o, done_oe, gflop, chain_oe}, 4'b1100);
    rb <= 8'h2D;
    host_u.cyc(1'b0, 1'b0, 1'b1, 8'hFF, q);
    // The synced rise is acted on one edge after the host's cycle ends
    repeat (2) @(posedge clk);
    chk({bus_oe, bus_o}, 9'h1B4);
    chk(expq.size(), 0);
    host_u.park;
    restart(`CSBP_MODE_PAR);
    put(1'b1, 8'hA5);
    host_u.cyc(1'b0, 1'b0, 1'b1, 8'h00, q);
    repeat (2) @(posedge clk);
    chk({err, init_oe}, 2'b11);
    print_verdict;
  end
endmodule
